/* rtl/mmr_pkg.sv */
// constants and types for the register-operand multiply unit
// What this block does
// - decode fixed opcode, bit 8 bank select, low byte address; zero means access bank
// - bank select one combines address with the bank select register
// - unsigned accumulator times operand into high and low product bytes
// - accumulator and operand location never written; only product bytes change
// - no status flag changes; zero product not signalled
// - extended set, bank select zero, address at most 95: indexed literal offset
package mmr_pkg;
  localparam logic [6:0]  MMR_OPC_TOP    = 7'h01;
  localparam int          MMR_OPC_MSB    = 15;
  localparam int          MMR_OPC_LSB    = 9;
  localparam int          MMR_BANKSEL    = 8;
  localparam logic [7:0]  MMR_IDX_LIMIT  = 8'h5f;
  localparam logic [7:0]  MMR_ACC_SPLIT  = 8'h60;
  localparam logic [3:0]  MMR_SFR_BANK   = 4'hf;
  localparam logic [3:0]  MMR_LOW_BANK   = 4'h0;
  localparam logic [7:0]  MMR_BYTE_ZERO  = 8'h00;
  localparam logic [11:0] MMR_ADDR_ZERO  = 12'h000;
  typedef enum logic [1:0] {MMR_DECODE, MMR_READ, MMR_PROC, MMR_WRITE}
    mmr_phase_t;
endpackage

/* rtl/mmr_mult8.sv */
// unsigned 8x8 multiplier core, purely combinational
`timescale 1ns/1ps
module mmr_mult8
  import mmr_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic [WIDTH-1:0]   factorA,
  input  wire logic [WIDTH-1:0]   factorB,
  output logic      [2*WIDTH-1:0] product
);
  // refused at elaboration: a zero-width factor has no product
  if (WIDTH < 1)
  begin : g_width_check
    $error("mmr_mult8 width must be positive");
  end

  // zero-extended so the product is never truncated or signed
  assign product = {{WIDTH{1'b0}}, factorA} * {{WIDTH{1'b0}}, factorB};
endmodule

/* rtl/mmr_mul_unit.sv */
// register-operand multiply execution unit, four phases per instruction
`timescale 1ns/1ps
module mmr_mul_unit
  import mmr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        instrValid,
  input  wire logic [15:0] instrWord,
  input  wire logic [7:0]  accumIn,
  input  wire logic [3:0]  bankSelectIn,
  input  wire logic        extSetEnable,
  input  wire logic [11:0] indexBase,
  input  wire logic [7:0]  memRdData,
  output logic             instrReady,
  output logic             memRd,
  output logic      [11:0] memAddr,
  output logic             memWr,
  output logic             accumWr,
  output logic             flagWr,
  output logic             prodWr,
  output logic      [7:0]  productHighByte,
  output logic      [7:0]  productLowByte
);
  typedef struct packed {
    mmr_phase_t  phase;
    logic        active;
    logic [11:0] addr;
    logic [7:0]  operand;
    logic [15:0] product;
    logic        wrPulse;
    logic [7:0]  prodHigh;
    logic [7:0]  prodLow;
  } mmr_state_t;

  mmr_state_t stateReg;
  mmr_state_t stateNext;
  logic [15:0] mulOut;
  logic        isMul;
  logic        bankSel;
  logic [7:0]  opAddr;
  logic [11:0] effAddr;
  logic        acceptMul;

  mmr_mult8 #(.WIDTH(8)) uMult (
    .factorA (accumIn),
    .factorB (stateReg.operand),
    .product (mulOut)
  );

  assign isMul   = instrWord[MMR_OPC_MSB:MMR_OPC_LSB] == MMR_OPC_TOP;
  assign bankSel = instrWord[MMR_BANKSEL];
  assign opAddr  = instrWord[7:0];
  assign acceptMul = instrReady && instrValid && isMul;

  always_comb
  begin
    if (bankSel)
      effAddr = {bankSelectIn, opAddr};
    else if (extSetEnable && opAddr <= MMR_IDX_LIMIT)
      effAddr = indexBase + {4'h0, opAddr};
    else if (opAddr < MMR_ACC_SPLIT)
      effAddr = {MMR_LOW_BANK, opAddr};
    else
      effAddr = {MMR_SFR_BANK, opAddr};
  end

  always_comb
  begin
    stateNext = stateReg;
    stateNext.wrPulse = 1'b0;
    case (stateReg.phase)
      MMR_DECODE:
      begin
        // a word that is not this multiply is left to other units
        stateNext.active = instrValid && isMul;
        // address moves only on a new multiply, so it stands until then
        if (instrValid && isMul)
        begin
          stateNext.addr = effAddr;
          stateNext.phase = MMR_READ;
        end
      end
      MMR_READ:
      begin
        stateNext.operand = memRdData;
        stateNext.phase = MMR_PROC;
      end
      MMR_PROC:
      begin
        stateNext.product = mulOut;
        stateNext.phase = MMR_WRITE;
      end
      MMR_WRITE:
      begin
        stateNext.prodHigh = stateReg.product[15:8];
        stateNext.prodLow = stateReg.product[7:0];
        stateNext.wrPulse = 1'b1;
        stateNext.active = 1'b0;
        stateNext.phase = MMR_DECODE;
      end
      default:
      begin
        stateNext.phase = MMR_DECODE;
        stateNext.active = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stateReg <= '{
        phase:    MMR_DECODE,
        active:   1'b0,
        addr:     MMR_ADDR_ZERO,
        operand:  MMR_BYTE_ZERO,
        product:  {MMR_BYTE_ZERO, MMR_BYTE_ZERO},
        wrPulse:  1'b0,
        prodHigh: MMR_BYTE_ZERO,
        prodLow:  MMR_BYTE_ZERO
      };
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

  assign instrReady      = stateReg.phase == MMR_DECODE;
  assign memRd           = stateReg.phase == MMR_READ;
  assign memAddr         = stateReg.addr;
  // source operand, accumulator and flags are never written by this unit
  assign memWr           = 1'b0;
  assign accumWr         = 1'b0;
  assign flagWr          = 1'b0;
  assign prodWr          = stateReg.wrPulse;
  assign productHighByte = stateReg.prodHigh;
  assign productLowByte  = stateReg.prodLow;

  a_phase_order: assert property (@(posedge clk) disable iff (rst)
    (instrReady && instrValid && isMul) |=> memRd ##1 !memRd ##1 !memRd
    ##1 (prodWr && instrReady))
    else $error("multiply did not finish in four phases");
  a_prod_value: assert property (@(posedge clk) disable iff (rst)
    memRd |=> ##2 ({productHighByte, productLowByte}
      == $past(accumIn, 2) * $past(memRdData, 3)))
    else $error("product bytes wrong");
  a_prod_stable: assert property (@(posedge clk) disable iff (rst)
    !prodWr |-> $stable({productHighByte, productLowByte}))
    else $error("product changed without write");
  a_no_side_write: assert property (@(posedge clk) disable iff (rst)
    !memWr && !accumWr)
    else $error("multiply wrote a source");
  a_no_flag_write: assert property (@(posedge clk) disable iff (rst)
    !flagWr)
    else $error("multiply touched a flag");
  a_banked_addr: assert property (@(posedge clk) disable iff (rst)
    (instrReady && instrValid && isMul && bankSel)
    |=> memAddr == {$past(bankSelectIn), $past(opAddr)})
    else $error("banked address wrong");
  a_indexed_addr: assert property (@(posedge clk) disable iff (rst)
    (instrReady && instrValid && isMul && !bankSel && extSetEnable
     && opAddr <= MMR_IDX_LIMIT)
    |=> memAddr == $past(indexBase) + {4'h0, $past(opAddr)})
    else $error("indexed literal address wrong");
  a_access_addr: assert property (@(posedge clk) disable iff (rst)
    (instrReady && instrValid && isMul && !bankSel && !extSetEnable)
    |=> memAddr[7:0] == $past(opAddr))
    else $error("access bank address wrong");
  a_other_ignored: assert property (@(posedge clk) disable iff (rst)
    (instrReady && instrValid && !isMul) |=> instrReady)
    else $error("non-multiply word started the unit");

  // access bank: low part from bank zero, upper part from the top bank
  a_access_split: assert property (@(posedge clk) disable iff (rst)
    (acceptMul && !bankSel
     && !(extSetEnable && opAddr <= MMR_IDX_LIMIT))
    |=> memAddr == (($past(opAddr) < MMR_ACC_SPLIT)
      ? {MMR_LOW_BANK, $past(opAddr)}
      : {MMR_SFR_BANK, $past(opAddr)}))
    else $error("access bank split wrong");
  a_ext_off_low: assert property (@(posedge clk) disable iff (rst)
    (acceptMul && !bankSel && !extSetEnable && opAddr < MMR_ACC_SPLIT)
    |=> memAddr[11:8] == MMR_LOW_BANK)
    else $error("indexed mode used with extended set off");
  a_addr_hold: assert property (@(posedge clk) disable iff (rst)
    !acceptMul
    |=> $stable(memAddr))
    else $error("operand address moved without a new multiply");

  a_read_pulse: assert property (@(posedge clk) disable iff (rst)
    memRd |-> !instrReady ##1 (!memRd && !instrReady))
    else $error("operand read not a single busy cycle");
  a_operand_take: assert property (@(posedge clk) disable iff (rst)
    memRd |=> stateReg.operand == $past(memRdData))
    else $error("operand not taken in the read phase");
  a_write_pulse: assert property (@(posedge clk) disable iff (rst)
    prodWr |-> instrReady ##1 !prodWr)
    else $error("product write not a single pulse");
  a_idle_no_read: assert property (@(posedge clk) disable iff (rst)
    instrReady |-> !memRd)
    else $error("operand read while idle");

  // offers while busy are dropped rather than queued
  a_busy_ignored: assert property (@(posedge clk) disable iff (rst)
    (!instrReady && instrValid && !memRd) |=> !memRd)
    else $error("offer taken while busy");
  a_other_quiet: assert property (@(posedge clk) disable iff (rst)
    (instrReady && instrValid && !isMul) |=> !memRd && !prodWr)
    else $error("non-multiply word caused activity");

  c_banked: cover property (@(posedge clk) disable iff (rst)
    instrReady && instrValid && isMul && bankSel ##4 prodWr);
  c_indexed: cover property (@(posedge clk) disable iff (rst)
    instrReady && instrValid && isMul && !bankSel && extSetEnable);
  c_zero_prod: cover property (@(posedge clk) disable iff (rst)
    prodWr && productHighByte == MMR_BYTE_ZERO
    && productLowByte == MMR_BYTE_ZERO);
  c_access_high: cover property (@(posedge clk) disable iff (rst)
    acceptMul && !bankSel && opAddr >= MMR_ACC_SPLIT);
  c_back_to_back: cover property (@(posedge clk) disable iff (rst)
    prodWr && instrValid && isMul ##4 prodWr);
endmodule

/* verification/mmr_mul_unit_tb.sv */
// self-checking bench for the register-operand multiply unit
`timescale 1ns/1ps
module mmr_mul_unit_tb;
  import mmr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        instrValid = 1'b0;
  logic        extSetEnable = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic [7:0]  accumIn = 8'h00;
  logic [7:0]  memRdData = 8'h00;
  logic [3:0]  bankSelectIn = 4'h0;
  logic [11:0] indexBase = 12'h000;
  logic        instrReady, memRd, memWr, accumWr, flagWr, prodWr;
  logic [11:0] memAddr;
  logic [7:0]  productHighByte, productLowByte;
  int          mismatches = 0;
  int          cmpCount = 0;

  mmr_mul_unit DUT (.clk, .rst, .instrValid, .instrWord, .accumIn,
    .bankSelectIn, .extSetEnable, .indexBase, .memRdData, .instrReady,
    .memRd, .memAddr, .memWr, .accumWr, .flagWr, .prodWr,
    .productHighByte, .productLowByte);

  always #20 clk = ~clk;

  task automatic close_out;
    if (mismatches == 0 && cmpCount > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // valid stays up through the read and process phases so a refused offer would show as a retake
  task automatic do_mul(input logic [15:0] w, input logic [7:0] a, d,
    input logic [3:0] b, input logic e, input logic [11:0] x, ea);
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= w;
    accumIn <= a;
    memRdData <= d;
    bankSelectIn <= b;
    extSetEnable <= e;
    indexBase <= x;
    @(posedge clk);
    for (int i = 1; i < 5; i++)
    begin
      #1;
      chk(16'(memRd), 16'(i == 1));
      chk(16'(prodWr), 16'(i == 4));
      chk(16'({memWr, accumWr, flagWr}), 16'h0000);
      if (i == 1)
        chk(16'(memAddr), 16'(ea));
      if (i < 4)
        @(posedge clk);
      // stale operand or accumulator must not leak into the product
      if (i == 1)
        memRdData <= ~d;
      if (i == 2)
        instrValid <= 1'b0;
      if (i == 2)
        accumIn <= ~a;
    end
    chk({productHighByte, productLowByte}, 16'(a) * 16'(d));
    chk(16'(instrReady), 16'h0001);
  endtask

  task automatic t_banked;
    do_mul(16'h03a7, 8'hc4, 8'hb5, 4'h5, 1'b0, 12'h300, 12'h5a7);
  endtask

  task automatic t_access;
    do_mul(16'h0220, 8'h12, 8'h34, 4'h5, 1'b0, 12'h300, 12'h020);
    do_mul(16'h0280, 8'h0f, 8'hf1, 4'h5, 1'b0, 12'h300, 12'hf80);
  endtask

  task automatic t_indexed;
    do_mul(16'h025f, 8'hff, 8'hff, 4'h2, 1'b1, 12'h1a0, 12'h1ff);
    do_mul(16'h0260, 8'h80, 8'h02, 4'h2, 1'b1, 12'h1a0, 12'hf60);
    do_mul(16'h0310, 8'h07, 8'h09, 4'h2, 1'b1, 12'h1a0, 12'h210);
  endtask

  task automatic t_zero;
    do_mul(16'h0300, 8'h00, 8'h9c, 4'hc, 1'b0, 12'h000, 12'hc00);
  endtask

  task automatic t_other;
    logic [15:0] held;
    held = {productHighByte, productLowByte};
    @(posedge clk);
    instrWord <= 16'h0d05;
    instrValid <= 1'b1;
    repeat (4)
    begin
      @(posedge clk);
      #1;
      chk(16'({memRd, prodWr}), 16'h0000);
      chk(16'(memAddr), 16'h0c00);
    end
    chk({productHighByte, productLowByte}, held);
    @(posedge clk);
    instrValid <= 1'b0;
  endtask

  // reset cuts a multiply in flight; the unit must come back idle
  task automatic t_reset;
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= 16'h0311;
    @(posedge clk);
    instrValid <= 1'b0;
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1;
    chk(16'({instrReady, memRd, prodWr}), 16'h0004);
    chk({productHighByte, productLowByte}, 16'h0000);
    chk(16'(memAddr), 16'h0000);
    @(posedge clk);
    rst <= 1'b0;
    do_mul(16'h0240, 8'h5a, 8'h3c, 4'h1, 1'b1, 12'h010, 12'h050);
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(16'({instrReady, memRd, prodWr}), 16'h0004);
    chk({productHighByte, productLowByte}, 16'h0000);
    t_banked();
    t_reset();
    t_access();
    t_indexed();
    t_zero();
    t_other();
    close_out();
  end

  initial
  begin
    repeat (1000) @(posedge clk);
    mismatches++;
    close_out();
  end
endmodule
